// ===== verilog/cpu_bus_cycle_sequencer.sv
// machine-cycle sequencer with bus pins and an AHB-Lite command port
// assumes a single slave on the bus and asynchronous ready and data pins
`timescale 1ns/1ps
module cpu_bus_cycle_sequencer
	import cpu_seq_pkg::*;
#(
	parameter int STATE_DIV = STATE_DIV_DEFAULT
) (
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        readyPin,
	input  wire logic [7:0]  dataIn,
	output logic      [15:0] address,
	output logic      [7:0]  dataOut,
	output logic             dataOe,
	output logic             syncOut,
	output logic             inputStrobe,
	output logic             writeStrobeN,
	output logic             waitOut,
	output logic             phi1Out,
	output logic             phi2Out
);
	logic       phi1Tick;
	logic       phi2Tick;
	logic       phi1Level;
	logic       phi2Level;
	logic       readySync;
	logic [7:0] dataSync;

	phase_tick_gen #(
		.DIV(STATE_DIV)
	) u_ticks (
		.clock    (clock),
		.reset    (reset),
		.phi1Tick (phi1Tick),
		.phi2Tick (phi2Tick),
		.phi1Level(phi1Level),
		.phi2Level(phi2Level)
	);

	sync2 #(
		.WIDTH(9)
	) u_sync (
		.clock(clock),
		.reset(reset),
		.din  ({readyPin, dataIn}),
		.dout ({readySync, dataSync})
	);

	// status word built from cycle type, one bit per meaning
	function automatic logic [7:0] statusWord(input logic [3:0] cy);
		logic [7:0] s;
		s = 8'h00;
		s[ST_IRQ_ACK]  = (cy == CY_INTACK) || (cy == CY_HALTINT);
		s[ST_RNW]      = !((cy == CY_MEMWR) || (cy == CY_STACKWR) || (cy == CY_OUTPUT));
		s[ST_STACK]    = (cy == CY_STACKRD) || (cy == CY_STACKWR);
		s[ST_HALT_ACK] = (cy == CY_HALT) || (cy == CY_HALTINT);
		s[ST_OUT]      = (cy == CY_OUTPUT);
		s[ST_FETCH]    = (cy == CY_FETCH) || (cy == CY_INTACK) || (cy == CY_HALTINT);
		s[ST_INP]      = (cy == CY_INPUT);
		s[ST_MEM_READ_STATUS]     = (cy == CY_FETCH) || (cy == CY_MEMRD) || (cy == CY_STACKRD)
		                 || (cy == CY_HALT);
		return s;
	endfunction : statusWord

	function automatic logic isWrite(input logic [3:0] cy);
		return (cy == CY_MEMWR) || (cy == CY_STACKWR) || (cy == CY_OUTPUT);
	endfunction : isWrite

	function automatic logic isStrobeRead(input logic [3:0] cy);
		return (cy == CY_FETCH) || (cy == CY_MEMRD) || (cy == CY_STACKRD)
		       || (cy == CY_INTACK);
	endfunction : isStrobeRead

	function automatic logic isHalt(input logic [3:0] cy);
		return (cy == CY_HALT) || (cy == CY_HALTINT);
	endfunction : isHalt

	// bus slave state
	logic        apValid_q;
	logic        apWrite_q;
	logic [7:0]  apOfs_q;
	logic [15:0] cmd_q;
	logic [15:0] addr_q;
	logic        pending_q;
	logic [7:0]  readData_q;
	logic [7:0]  lastStatus_q;

	// sequencer state
	seq_state_t  state_q;
	seq_state_t  state_d;
	logic [3:0]  curType_q;
	logic [1:0]  curExtra_q;
	logic [7:0]  curWdata_q;
	logic [15:0] curAddr_q;
	logic        readyLatch_q;
	logic        take;
	logic        leaveHalt;

	wire logic apTake = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
	wire logic dpWrite = apValid_q && apWrite_q;

	always_ff @(posedge clock) begin
		if (reset) begin
			apValid_q <= 1'b0;
			apWrite_q <= 1'b0;
			apOfs_q   <= 8'h00;
		end else if (hready) begin
			apValid_q <= apTake;
			apWrite_q <= hwrite;
			apOfs_q   <= haddr[7:0];
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			cmd_q  <= 16'h0000;
			addr_q <= ADDR_RESET;
		end else if (dpWrite) begin
			if (apOfs_q == REG_CMD_OFS) begin
				cmd_q <= hwdata[15:0];
			end
			if (apOfs_q == REG_ADDR_OFS) begin
				addr_q <= hwdata[15:0];
			end
		end
	end

	// a new command write wins over the take in the same cycle
	always_ff @(posedge clock) begin
		if (reset) begin
			pending_q <= 1'b0;
		end else if (dpWrite && apOfs_q == REG_CMD_OFS) begin
			pending_q <= 1'b1;
		end else if (take) begin
			pending_q <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h0000_0000;
			if (apTake && !hwrite) begin
				unique case (haddr[7:0])
					REG_CMD_OFS:    hrdata <= {16'h0000, cmd_q};
					REG_ADDR_OFS:   hrdata <= {16'h0000, addr_q};
					REG_STATUS_OFS: begin
						hrdata[STS_PEND_BIT]                <= pending_q;
						hrdata[STS_STATE_LSB +: 6]          <= state_q;
						hrdata[STS_WAIT_BIT]                <= waitOut;
						hrdata[STS_RDATA_LSB +: 8]          <= readData_q;
						hrdata[STS_WORD_LSB +: 8]           <= lastStatus_q;
					end
					default:        hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// state transitions on the phase-one tick
	assign leaveHalt = isHalt(curType_q) && pending_q;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			S_T1: state_d = S_T2;
			S_T2: begin
				if (isHalt(curType_q) || !readyLatch_q) begin
					state_d = S_TW;
				end else begin
					state_d = S_T3;
				end
			end
			S_TW: begin
				if (leaveHalt) begin
					state_d = S_T1;
				end else if (!isHalt(curType_q) && readyLatch_q) begin
					state_d = S_T3;
				end
			end
			S_T3: state_d = (curExtra_q != 2'h0) ? S_T4 : S_T1;
			S_T4: state_d = (curExtra_q == 2'h2) ? S_T5 : S_T1;
			S_T5: state_d = S_T1;
		endcase
	end

	assign take = phi1Tick && (state_d == S_T1) && (state_q != S_T1);

	always_ff @(posedge clock) begin
		if (reset) begin
			state_q <= S_T1;
		end else if (phi1Tick) begin
			state_q <= state_d;
		end
	end

	// cycle parameters loaded at entry to the first state
	always_ff @(posedge clock) begin
		if (reset) begin
			curType_q  <= CY_FETCH;
			curExtra_q <= FETCH_EXTRA_RESET;
			curWdata_q <= 8'h00;
			curAddr_q  <= ADDR_RESET;
		end else if (take) begin
			if (pending_q) begin
				curType_q  <= cmd_q[CMD_TYPE_LSB +: 4];
				curExtra_q <= (cmd_q[CMD_EXTRA_LSB +: 2] == 2'h3) ? 2'h2
				              : cmd_q[CMD_EXTRA_LSB +: 2];
				curWdata_q <= cmd_q[CMD_WDATA_LSB +: 8];
				curAddr_q  <= addr_q;
			end else begin
				curType_q  <= CY_HALT;
				curExtra_q <= 2'h0;
				curAddr_q  <= addr_q;
			end
		end
	end

	// ready sampled at phase two of the second or a wait state
	always_ff @(posedge clock) begin
		if (reset) begin
			readyLatch_q <= 1'b0;
		end else if (phi2Tick && (state_q == S_T2 || state_q == S_TW)) begin
			readyLatch_q <= readySync;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			waitOut <= 1'b0;
		end else if (phi1Tick) begin
			waitOut <= (state_d == S_TW);
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			syncOut <= 1'b0;
		end else if (phi2Tick) begin
			syncOut <= (state_q == S_T1);
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			address <= ADDR_RESET;
		end else if (phi2Tick && state_q == S_T1) begin
			address <= curAddr_q;
		end
	end

	// data bus: status, then output data or release for input
	always_ff @(posedge clock) begin
		if (reset) begin
			dataOut      <= 8'h00;
			dataOe       <= 1'b0;
			lastStatus_q <= 8'h00;
		end else if (phi2Tick) begin
			if (state_q == S_T1) begin
				dataOut      <= statusWord(curType_q);
				dataOe       <= 1'b1;
				lastStatus_q <= statusWord(curType_q);
			end else if (state_q == S_T2) begin
				if (isWrite(curType_q)) begin
					dataOut <= curWdata_q;
					dataOe  <= 1'b1;
				end else begin
					dataOe  <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			inputStrobe <= 1'b0;
		end else if (phi2Tick) begin
			if (state_q == S_T2 && isStrobeRead(curType_q)) begin
				inputStrobe <= 1'b1;
			end else if (state_q == S_T3) begin
				inputStrobe <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			readData_q <= 8'h00;
		end else if (phi2Tick && state_q == S_T3 && !isWrite(curType_q)) begin
			readData_q <= dataSync;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			writeStrobeN <= 1'b1;
		end else if (phi1Tick) begin
			if (state_q == S_T2 && isWrite(curType_q) && !isHalt(curType_q)) begin
				writeStrobeN <= 1'b0;
			end else if (state_q == S_T3) begin
				writeStrobeN <= 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			phi1Out <= 1'b0;
			phi2Out <= 1'b0;
		end else begin
			phi1Out <= phi1Level;
			phi2Out <= phi2Level;
		end
	end

	wire logic unusedBits = ^{hsize, hwdata[31:16]};
endmodule : cpu_bus_cycle_sequencer

// ===== verilog/cpu_seq_pkg.sv
// constants and cycle encodings for the machine-cycle sequencer
// assumes a single 250 MHz clock and an AHB-Lite register master
// Functional notes
// - a machine cycle holds three to five basic and internal states, plus any wait states
// - states advance on each first-phase rising tick; all states whole periods
// - cycle-start pulse only in first state, phase-two to phase-two, with status
// - address loads at phase two of first state, held past third state
// - ready low during second or wait state sends sequencer to wait state
// - wait output rises at the first-phase tick entering the wait state
// - wait repeats while ready low; ready high then moves to third state
// - an 8-bit status word drives the data bus at each cycle start
// - status bit 0 flags interrupt acknowledge for external restart gating
// - status bit 1 is 0 for write or output, 1 for read or input
// - status bit 2 set when address bus carries the stack pointer
// - status bit 3 acknowledges an executed halt
// - status bit 4 set for output port address; data during write strobe
// - status bit 5 set in instruction fetch, interrupt acknowledge and halted-interrupt cycles
// - status bit 6 set for input port address; no input strobe, port data sampled in third state
// - status bit 7 set when the bus will carry memory read data
// - third state samples opcode or data on reads, drives data on writes
// - input cycles release status at phase two of second state, sample in third
// - input strobe from phase two of second to phase two of third state
// - output data replaces status at phase two of second state until next status
// - output cycle needs ready high; waits keep output data unchanged
// - write strobe low from first phase-one after second state to state after third
// - cycle ends after third, fourth or fifth state, then first state again
// - second state samples ready and checks halt; halt enters wait state
package cpu_seq_pkg;
	localparam int          STATE_DIV_DEFAULT = 4;
	localparam logic [7:0]  REG_CMD_OFS    = 8'h00;
	localparam logic [7:0]  REG_ADDR_OFS   = 8'h04;
	localparam logic [7:0]  REG_STATUS_OFS = 8'h08;
	localparam int          CMD_TYPE_LSB   = 0;
	localparam int          CMD_EXTRA_LSB  = 4;
	localparam int          CMD_WDATA_LSB  = 8;
	localparam int          STS_PEND_BIT   = 0;
	localparam int          STS_STATE_LSB  = 1;
	localparam int          STS_WAIT_BIT   = 7;
	localparam int          STS_RDATA_LSB  = 8;
	localparam int          STS_WORD_LSB   = 16;
	localparam logic [15:0] ADDR_RESET     = 16'h0000;
	localparam logic [1:0]  FETCH_EXTRA_RESET = 2'h1;
	localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
	localparam logic [1:0]  HTRANS_SEQ     = 2'h3;

	localparam logic [3:0] CY_FETCH    = 4'h0;
	localparam logic [3:0] CY_MEMRD    = 4'h1;
	localparam logic [3:0] CY_MEMWR    = 4'h2;
	localparam logic [3:0] CY_STACKRD  = 4'h3;
	localparam logic [3:0] CY_STACKWR  = 4'h4;
	localparam logic [3:0] CY_INPUT    = 4'h5;
	localparam logic [3:0] CY_OUTPUT   = 4'h6;
	localparam logic [3:0] CY_INTACK   = 4'h7;
	localparam logic [3:0] CY_HALT     = 4'h8;
	localparam logic [3:0] CY_HALTINT  = 4'h9;

	localparam int ST_IRQ_ACK  = 0;
	localparam int ST_RNW      = 1;
	localparam int ST_STACK    = 2;
	localparam int ST_HALT_ACK = 3;
	localparam int ST_OUT      = 4;
	localparam int ST_FETCH    = 5;
	localparam int ST_INP      = 6;
	localparam int ST_MEM_READ_STATUS     = 7;

	typedef enum logic [5:0] {
		S_T1 = 6'b000001,
		S_T2 = 6'b000010,
		S_TW = 6'b000100,
		S_T3 = 6'b001000,
		S_T4 = 6'b010000,
		S_T5 = 6'b100000
	} seq_state_t;
endpackage : cpu_seq_pkg

// ===== verilog/phase_tick_gen.sv
// divides the system clock into state periods and two phase ticks
// assumes one clock; phase-one tick starts a state, phase-two tick follows
`timescale 1ns/1ps
module phase_tick_gen #(
	parameter int DIV = 4
) (
	input  wire logic clock,
	input  wire logic reset,
	output logic      phi1Tick,
	output logic      phi2Tick,
	output logic      phi1Level,
	output logic      phi2Level
);
	logic [7:0] count_q;

	always_ff @(posedge clock) begin
		if (reset) begin
			// reset lands in the first state, so its phase-two tick must still follow
			count_q <= 8'h01;
		end else if (count_q == 8'(DIV - 1)) begin
			count_q <= 8'h00;
		end else begin
			count_q <= count_q + 8'h01;
		end
	end

	assign phi1Tick  = (count_q == 8'h00);
	assign phi2Tick  = (count_q == 8'h01);
	assign phi1Level = (count_q == 8'h00);
	assign phi2Level = (count_q == 8'h01) || (count_q == 8'h02);
endmodule : phase_tick_gen

// ===== verilog/sync2.sv
// two-flop synchroniser for pin inputs
// assumes inputs are asynchronous to clock
`timescale 1ns/1ps
module sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clock,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clock) begin
		if (reset) begin
			meta_q <= '0;
			dout   <= '0;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule : sync2

// ===== verif/cpu_seq_sva.sv
// assertions on the sequencer bus pins
// bound to the sequencer top; one clock domain, synchronous reset
`timescale 1ns/1ps
module cpu_seq_sva #(
	parameter int STATE_DIV = 4
) (
	input wire logic        clock,
	input wire logic        reset,
	input wire logic [15:0] address,
	input wire logic [7:0]  dataOut,
	input wire logic        dataOe,
	input wire logic        syncOut,
	input wire logic        inputStrobe,
	input wire logic        writeStrobeN,
	input wire logic        waitOut,
	input wire logic        phi1Out,
	input wire logic        phi2Out
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	a_sync_width: assert property ($rose(syncOut) |-> syncOut[*4] ##1 !syncOut)
		else $error("sync pulse width wrong");
	a_status_drive: assert property (syncOut |-> dataOe)
		else $error("status not driven");
	a_addr_hold: assert property ($changed(address) |-> $rose(syncOut))
		else $error("address moved outside first state");
	a_wait_entry: assert property ($rose(waitOut) |-> $past(syncOut, 4) && !$past(syncOut, 3))
		else $error("wait entered off second state");
	a_wait_whole: assert property ($rose(waitOut) |-> waitOut[*4])
		else $error("wait not whole state");
	a_wr_entry: assert property ($fell(writeStrobeN) |-> $past(syncOut, 4) && !$past(syncOut, 3))
		else $error("write strobe fell late");
	a_wr_data: assert property (!writeStrobeN |-> dataOe && $stable(dataOut))
		else $error("write data not held");
	a_rd_start: assert property ($rose(inputStrobe) |-> $fell(syncOut) && !dataOe)
		else $error("read strobe start wrong");
	a_rd_width: assert property ($rose(inputStrobe) |-> inputStrobe[*4])
		else $error("read strobe too short");
	a_strobe_excl: assert property (!(inputStrobe && !writeStrobeN))
		else $error("both strobes active");
	a_sync_phase: assert property ($rose(syncOut) |-> phi2Out && !phi1Out)
		else $error("sync rose off phase two");
	a_wait_phase: assert property ($rose(waitOut) |-> phi1Out && !phi2Out)
		else $error("wait rose off phase one");
	a_wr_phase: assert property ($fell(writeStrobeN) |-> phi1Out && !phi2Out)
		else $error("write strobe fell off phase one");
	c_wait: cover property ($rose(waitOut));
	c_write: cover property ($fell(writeStrobeN));
	c_read: cover property ($rose(inputStrobe));
endmodule : cpu_seq_sva

// ===== verif/bus_peripheral_model.sv
// memory and port model on the sequencer pins
// latches status at sync, stalls ready on request, returns read bytes
`timescale 1ns/1ps
module bus_peripheral_model #(
	parameter logic [7:0] RESTART_BYTE = 8'hD7
) (
	input wire logic        clock,
	input wire logic        reset,
	input wire logic [3:0]  waitPeriods,
	input wire logic [15:0] address,
	input wire logic [7:0]  dataOut,
	input wire logic        syncOut,
	output logic            readyPin,
	output logic     [7:0]  dataIn
);
	logic       syncPrev;
	logic       driveQ;
	logic [7:0] waitCnt;
	logic [7:0] byteQ;
	// ready drops from the sync edge on, so the second state already sees it low
	assign readyPin = (waitCnt == 8'h00);
	always_ff @(posedge clock) begin
		if (reset) begin
			syncPrev <= 1'b0;
			driveQ <= 1'b0;
			waitCnt <= 8'h00;
			byteQ <= 8'h00;
		end else begin
			syncPrev <= syncOut;
			if (syncOut && !syncPrev) begin
				waitCnt <= dataOut[3] ? 8'h00 : {2'b00, waitPeriods, 2'b00};
				driveQ <= dataOut[7] | dataOut[6] | dataOut[0];
				byteQ <= dataOut[0] ? RESTART_BYTE : address[7:0] ^ 8'h5A;
			end else if (waitCnt != 8'h00)
				waitCnt <= waitCnt - 8'h01;
		end
	end
	always_ff @(posedge clock) begin
		if (reset)
			dataIn <= 8'h00;
		else
			dataIn <= driveQ ? byteQ : ~dataIn;
	end
endmodule : bus_peripheral_model

// ===== verif/test_cpu_bus_cycle_sequencer.sv
// self-checking bench for the machine-cycle sequencer
// assumes the peripheral model on the pins and this bench as bus master
`timescale 1ns/1ps
module test_cpu_bus_cycle_sequencer
	import cpu_seq_pkg::*;
();
	localparam logic [7:0] RESTART_BYTE = 8'hD7;
	localparam logic [7:0] STAT_TBL [10] = '{8'hA2, 8'h82, 8'h00, 8'h86, 8'h04,
		8'h42, 8'h10, 8'h23, 8'h8A, 8'h2B};
	logic        clock = 1'b0;
	logic        reset = 1'b1;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [3:0]  waitPeriods = 4'h0;
	logic [31:0] hrdata;
	logic        hreadyout, hresp, readyPin, dataOe, syncOut, inputStrobe;
	logic        writeStrobeN, waitOut, phi1Out, phi2Out;
	logic [7:0]  dataIn, dataOut;
	logic [15:0] address;
	int          error_cnt = 0;
	int          compares = 0;
	always #2 clock = ~clock;
	cpu_bus_cycle_sequencer #(.STATE_DIV(4)) dut_u (.clock(clock), .reset(reset),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .readyPin(readyPin), .dataIn(dataIn), .address(address),
		.dataOut(dataOut), .dataOe(dataOe), .syncOut(syncOut), .inputStrobe(inputStrobe),
		.writeStrobeN(writeStrobeN), .waitOut(waitOut), .phi1Out(phi1Out),
		.phi2Out(phi2Out));
	bus_peripheral_model #(.RESTART_BYTE(RESTART_BYTE)) model_u (.clock(clock),
		.reset(reset), .waitPeriods(waitPeriods), .address(address), .dataOut(dataOut),
		.syncOut(syncOut), .readyPin(readyPin), .dataIn(dataIn));
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task results;
		if (error_cnt == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results
	task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		do @(posedge clock); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clock); while (hreadyout !== 1'b1);
		rd = hrdata;
		check("hresp", hresp, 1'b0);
	endtask : ahb
	task waitSync;
		logic p;
		p = 1'b1;
		while (!(syncOut === 1'b1 && p === 1'b0)) begin
			p = syncOut;
			@(posedge clock);
		end
	endtask : waitSync
	task runCycle(input int t, input int e, input int w);
		logic [31:0] rd;
		logic [15:0] a;
		logic [7:0]  wd;
		logic        p;
		int          len, wc, sc, wrc, sh;
		bit          halt;
		a = 16'h1234 + 16'(t) * 16'h0111;
		wd = 8'hC3 ^ 8'(t);
		halt = t >= 8;
		len = 0; wc = 0; sc = 0; wrc = 0; sh = 0;
		waitPeriods <= 4'(w);
		ahb(1'b1, 32'(REG_ADDR_OFS), {16'h0, a}, rd);
		ahb(1'b1, 32'(REG_CMD_OFS), {16'h0, wd, 2'b00, 2'(e), 4'(t)}, rd);
		waitSync();
		check("status", dataOut, STAT_TBL[t]);
		check("address", address, a);
		check("phase two", {phi1Out, phi2Out}, 2'b01);
		do begin
			p = syncOut;
			sh += (syncOut === 1'b1);
			wc += (waitOut === 1'b1);
			sc += (inputStrobe === 1'b1);
			wrc += (writeStrobeN === 1'b0);
			if (writeStrobeN === 1'b0) check("write data", dataOut, wd);
			@(posedge clock);
			len++;
		end while (!(syncOut === 1'b1 && p === 1'b0) && len < 300);
		check("sync width", sh, 4);
		if (halt) check("halt wait", waitOut, 1'b1);
		else begin
			check("cycle length", len, 4 * (3 + ((e == 3) ? 2 : e)) + wc);
			check("wait seen", wc > 0, w > 0);
			check("idle status", dataOut, 8'h8A);
		end
		if (t inside {0, 1, 3, 7}) check("read strobe", sc, wc + 4);
		if (t inside {2, 4, 6}) check("write strobe", wrc, wc + 4);
		ahb(1'b0, 32'(REG_STATUS_OFS), 32'h0, rd);
		check("last status", rd[23:16], halt ? STAT_TBL[t] : 8'h8A);
		check("pending", rd[STS_PEND_BIT], 1'b0);
		if (t inside {0, 1, 3, 5, 7})
			check("read data", rd[15:8], (t == 7) ? RESTART_BYTE : a[7:0] ^ 8'h5A);
	endtask : runCycle
	initial begin
		logic [31:0] rd;
		repeat (8) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		check("strobes idle", {inputStrobe, writeStrobeN, waitOut}, 3'b010);
		waitSync();
		check("reset fetch", {dataOut, address}, {8'hA2, ADDR_RESET});
		ahb(1'b0, 32'h0000_0040, 32'h0, rd);
		check("unmapped", rd, 32'h0);
		for (int i = 0; i < 10; i++)
			runCycle(i, i % 4, (i + 1) % 3);
		results();
	end
	initial begin
		#40000;
		error_cnt++;
		results();
	end
endmodule : test_cpu_bus_cycle_sequencer
bind cpu_bus_cycle_sequencer cpu_seq_sva #(.STATE_DIV(STATE_DIV)) chk_u (.clock(clock),
	.reset(reset), .address(address), .dataOut(dataOut), .dataOe(dataOe),
	.syncOut(syncOut), .inputStrobe(inputStrobe), .writeStrobeN(writeStrobeN),
	.waitOut(waitOut), .phi1Out(phi1Out), .phi2Out(phi2Out));
